// [verilog/pfsr_status_regs.sv]
// pfsr_status_regs.sv - live port status and latched port 1 fault status registers
`default_nettype none

// How it works
// - status bit 7 mirrors port 2 alert pin
// - status bit 6 mirrors port 1 alert pin
// - bits 5,4 show constant current per port
// - bits 1,0 read 1 while attach pins low
// - error bit reads 1 in Error state
// - writing error 0 rechecks, exits if clean
// - auto-recovery clears error once conditions gone
// - discharge failure sets discharge flag
// - reset indicator clears on read or enable toggle
// - low bus voltage sets keep-out flag
// - overtemperature sets thermal flag, enters Error
// - supply overvoltage sets flag, enters Error
// - bus above supplies by 150 mV sets flag
// - overcurrent needs both limit and region-2 minimum
// - fault flags clear on read if gone, or error clear
// - any fault flag asserts alert, enters Error
// - alert and error bit kept independent
// - host reaches single-byte registers via target engine

module pfsr_status_regs (
    input  wire logic       clk,
    input  wire logic       arst_n,
    // byte register port from the bus target engine
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_rd_stb,
    input  wire logic       reg_wr_stb,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata_q,
    // live pin levels, 1 = alert pin asserted
    input  wire logic       port1_alert_level,
    input  wire logic       port2_alert_level,
    // live attach pin levels, 0 = pin driven low
    input  wire logic       port1_attach_level,
    input  wire logic       port2_attach_level,
    input  wire logic       port1_const_current,
    input  wire logic       port2_const_current,
    // fault conditions from the analog detectors, high while present
    input  wire logic       discharge_fail_cond,
    input  wire logic       low_bus_cond,
    input  wire logic       thermal_cond,
    input  wire logic       supply_ov_cond,
    input  wire logic       back_bias_cond,
    input  wire logic       over_limit_cond,
    input  wire logic       over_region2_cond,
    // control levels
    input  wire logic       port_power_enable_ctrl,
    input  wire logic       auto_recovery_en,
    // results
    output logic            port1_alert_req_q,
    output logic            port1_error_q
);

    // ----------------------------------------------------------------
    // decode of host accesses
    // ----------------------------------------------------------------
    logic rd_fault;
    logic wr_fault;
    logic err_write_zero;

    // single-byte accesses only; port_pin_status ignores writes
    assign rd_fault       = reg_rd_stb && (reg_addr == pfsr_pkg::PFSR_ADDR_FAULT_STATUS);
    assign wr_fault       = reg_wr_stb && (reg_addr == pfsr_pkg::PFSR_ADDR_FAULT_STATUS);
    assign err_write_zero = wr_fault && !reg_wdata[pfsr_pkg::PFSR_FS_ERROR];

    // ----------------------------------------------------------------
    // fault conditions
    // ----------------------------------------------------------------
    logic                              overcurrent_cond;
    logic [pfsr_pkg::PFSR_NUM_FLAGS-1:0] cond_vec;
    logic                              any_cond;

    // overcurrent only when both thresholds are exceeded
    assign overcurrent_cond = over_limit_cond && over_region2_cond;

    // causes lined up with the flag bit positions
    always_comb begin
        cond_vec = '0;
        cond_vec[pfsr_pkg::PFSR_FS_DISCHARGE]   = discharge_fail_cond;
        cond_vec[pfsr_pkg::PFSR_FS_LOW_BUS]     = low_bus_cond;
        cond_vec[pfsr_pkg::PFSR_FS_THERMAL]     = thermal_cond;
        cond_vec[pfsr_pkg::PFSR_FS_SUPPLY_OV]   = supply_ov_cond;
        cond_vec[pfsr_pkg::PFSR_FS_BACK_BIAS]   = back_bias_cond;
        cond_vec[pfsr_pkg::PFSR_FS_OVERCURRENT] = overcurrent_cond;
    end

    assign any_cond = |(cond_vec & pfsr_pkg::PFSR_FAULT_MASK);

    // ----------------------------------------------------------------
    // reset indicator source and power enable toggle
    // ----------------------------------------------------------------
    logic boot_done_q;
    logic boot_done_d;
    logic port_power_enable_ctrl_q;
    logic port_power_enable_ctrl_d;
    logic port_power_enable_ctrl_toggle;
    logic reset_seen;

    // first cycle after reset release raises the reset indicator
    always_comb begin
        boot_done_d = 1'b1;
        port_power_enable_ctrl_d    = port_power_enable_ctrl;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            boot_done_q <= 1'b0;
            port_power_enable_ctrl_q    <= 1'b0;
        end else begin
            boot_done_q <= boot_done_d;
            port_power_enable_ctrl_q    <= port_power_enable_ctrl_d;
        end
    end

    assign reset_seen    = !boot_done_q;
    // enable edges are ignored in the boot cycle, the old value is not valid yet
    assign port_power_enable_ctrl_toggle = boot_done_q && (port_power_enable_ctrl_q != port_power_enable_ctrl);

    // ----------------------------------------------------------------
    // error state machine
    // ----------------------------------------------------------------
    pfsr_pkg::pfsr_state_type state_q;
    pfsr_pkg::pfsr_state_type state_d;
    logic                     err_clear;
    logic [pfsr_pkg::PFSR_NUM_FLAGS-1:0] flag_q;
    logic                     any_fault_flag;

    assign any_fault_flag = |(flag_q & pfsr_pkg::PFSR_FAULT_MASK);

    // next state and the clear pulse that wipes the fault flags
    always_comb begin
        state_d   = state_q;
        err_clear = 1'b0;
        case (state_q)
            pfsr_pkg::PFSR_ST_ACTIVE: begin
                if (any_fault_flag || any_cond) begin
                    state_d = pfsr_pkg::PFSR_ST_ERROR;
                end
            end
            pfsr_pkg::PFSR_ST_ERROR: begin
                if (err_write_zero && !any_cond) begin
                    state_d   = pfsr_pkg::PFSR_ST_ACTIVE;
                    err_clear = 1'b1;
                end else if (auto_recovery_en && !any_cond) begin
                    state_d   = pfsr_pkg::PFSR_ST_ACTIVE;
                    err_clear = 1'b1;
                end
            end
            default: begin
                state_d = pfsr_pkg::PFSR_ST_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= pfsr_pkg::PFSR_ST_ACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // latched flags
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < pfsr_pkg::PFSR_NUM_FLAGS; gi++) begin : g_flag
            if (gi == pfsr_pkg::PFSR_FS_RESET_IND) begin : g_rst
                // clears on any fault status read or enable toggle, untouched by error clear
                pfsr_sticky_flag u_flag (
                    .clk       (clk),
                    .arst_n    (arst_n),
                    .set_in    (reset_seen),
                    .cond_now  (1'b0),
                    .rd_clr    (rd_fault),
                    .force_clr (port_power_enable_ctrl_toggle),
                    .flag_q    (flag_q[gi])
                );
            end else begin : g_fault
                // condition present on a read keeps the flag set
                pfsr_sticky_flag u_flag (
                    .clk       (clk),
                    .arst_n    (arst_n),
                    .set_in    (cond_vec[gi]),
                    .cond_now  (cond_vec[gi]),
                    .rd_clr    (rd_fault),
                    .force_clr (err_clear),
                    .flag_q    (flag_q[gi])
                );
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // outputs: alert request and error level
    // ----------------------------------------------------------------
    logic alert_d;
    logic error_d;

    // alert follows the fault flags and the live fault conditions, error follows the state
    always_comb begin
        alert_d = |(flag_q & pfsr_pkg::PFSR_FAULT_MASK) || any_cond;
        error_d = (state_d == pfsr_pkg::PFSR_ST_ERROR);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            port1_alert_req_q <= 1'b0;
            port1_error_q     <= 1'b0;
        end else begin
            port1_alert_req_q <= alert_d;
            port1_error_q     <= error_d;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    logic [7:0] pin_status;
    logic [7:0] fault_status;
    logic [7:0] rdata_d;

    // live pin status; bits 3 and 2 stay zero
    always_comb begin
        pin_status = pfsr_pkg::PFSR_RESET_VALUE;
        pin_status[pfsr_pkg::PFSR_PS_PORT2_ALERT]  = port2_alert_level;
        pin_status[pfsr_pkg::PFSR_PS_PORT1_ALERT]  = port1_alert_level;
        pin_status[pfsr_pkg::PFSR_PS_PORT2_CC]     = port2_const_current;
        pin_status[pfsr_pkg::PFSR_PS_PORT1_CC]     = port1_const_current;
        pin_status[pfsr_pkg::PFSR_PS_PORT2_ATTACH] = !port2_attach_level;
        pin_status[pfsr_pkg::PFSR_PS_PORT1_ATTACH] = !port1_attach_level;
    end

    // fault status shows the value before any clear of this read
    always_comb begin
        fault_status = {(state_q == pfsr_pkg::PFSR_ST_ERROR), flag_q};
    end

    // unmapped addresses return zero
    always_comb begin
        rdata_d = reg_rdata_q;
        if (reg_rd_stb) begin
            case (reg_addr)
                pfsr_pkg::PFSR_ADDR_PIN_STATUS:   rdata_d = pin_status;
                pfsr_pkg::PFSR_ADDR_FAULT_STATUS: rdata_d = fault_status;
                default:                          rdata_d = pfsr_pkg::PFSR_RESET_VALUE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_q <= pfsr_pkg::PFSR_RESET_VALUE;
        end else begin
            reg_rdata_q <= rdata_d;
        end
    end

endmodule // pfsr_status_regs

`default_nettype wire

// [include/pfsr_pkg.sv]
// pfsr_pkg.sv - register map, field positions and states of the port fault status block
`default_nettype none

package pfsr_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] PFSR_ADDR_PIN_STATUS   = 8'h02;
    localparam logic [7:0] PFSR_ADDR_FAULT_STATUS = 8'h03;

    // ----------------------------------------------------------------
    // register widths and reset values
    // ----------------------------------------------------------------
    localparam int         PFSR_REG_W        = 8;
    localparam logic [7:0] PFSR_RESET_VALUE  = 8'h00;

    // ----------------------------------------------------------------
    // port_pin_status field positions
    // ----------------------------------------------------------------
    localparam int PFSR_PS_PORT2_ALERT  = 7;
    localparam int PFSR_PS_PORT1_ALERT  = 6;
    localparam int PFSR_PS_PORT2_CC     = 5;
    localparam int PFSR_PS_PORT1_CC     = 4;
    localparam int PFSR_PS_PORT2_ATTACH = 1;
    localparam int PFSR_PS_PORT1_ATTACH = 0;

    // ----------------------------------------------------------------
    // port1_fault_status field positions
    // ----------------------------------------------------------------
    localparam int PFSR_FS_ERROR       = 7;
    localparam int PFSR_FS_DISCHARGE   = 6;
    localparam int PFSR_FS_RESET_IND   = 5;
    localparam int PFSR_FS_LOW_BUS     = 4;
    localparam int PFSR_FS_THERMAL     = 3;
    localparam int PFSR_FS_SUPPLY_OV   = 2;
    localparam int PFSR_FS_BACK_BIAS   = 1;
    localparam int PFSR_FS_OVERCURRENT = 0;

    // number of latched flags below the error bit
    localparam int         PFSR_NUM_FLAGS  = 7;
    // latched flags that count as faults (reset indicator excluded)
    localparam logic [6:0] PFSR_FAULT_MASK = 7'h5F;

    // back-bias threshold, informative for the comparator feeding this block
    localparam int PFSR_BACK_BIAS_MV = 150;

    // ----------------------------------------------------------------
    // port 1 power state
    // ----------------------------------------------------------------
    typedef enum logic {
        PFSR_ST_ACTIVE,
        PFSR_ST_ERROR
    } pfsr_state_type;

endpackage

`default_nettype wire

// [verilog/pfsr_sticky_flag.sv]
// pfsr_sticky_flag.sv - one latched status flag, clear on read while its cause is gone
`default_nettype none

module pfsr_sticky_flag (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic set_in,
    input  wire logic cond_now,
    input  wire logic rd_clr,
    input  wire logic force_clr,
    output logic      flag_q
);

    logic flag_d;

    // set wins over any clear; read clears only when the cause is gone
    always_comb begin
        flag_d = flag_q;
        if ((rd_clr && !cond_now) || force_clr) begin
            flag_d = 1'b0;
        end
        if (set_in) begin
            flag_d = 1'b1;
        end
    end

    // flag register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

endmodule // pfsr_sticky_flag

`default_nettype wire

// [tb/pfsr_status_regs_monitor.sv]
// pfsr_status_regs_monitor.sv - port assertions for the port fault status registers
`default_nettype none

module pfsr_status_regs_monitor (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_rd_stb,
    input wire logic [7:0] reg_rdata_q,
    input wire logic       discharge_fail_cond,
    input wire logic       low_bus_cond,
    input wire logic       thermal_cond,
    input wire logic       supply_ov_cond,
    input wire logic       back_bias_cond,
    input wire logic       over_limit_cond,
    input wire logic       over_region2_cond,
    input wire logic       port1_alert_req_q,
    input wire logic       port1_error_q
);
    timeunit 1ns;
    timeprecision 1ps;

    logic any_cond;
    logic fs_rd;

    // live fault causes, overcurrent only when both thresholds are passed
    assign any_cond = discharge_fail_cond | low_bus_cond | thermal_cond | supply_ov_cond
                    | back_bias_cond | (over_limit_cond & over_region2_cond);
    assign fs_rd    = reg_rd_stb && reg_addr == pfsr_pkg::PFSR_ADDR_FAULT_STATUS;

    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // error entry, exit, alert and read-back relations
    chk_fault_entry: assert property (any_cond |=> port1_error_q && port1_alert_req_q)
        else $error("fault without error and alert");
    chk_no_fault: assert property (!port1_error_q && !port1_alert_req_q && !any_cond
        |=> !port1_error_q) else $error("error without fault");
    chk_err_read: assert property (fs_rd |=> reg_rdata_q[7] == $past(port1_error_q))
        else $error("error bit read wrong");
    chk_unmapped_zero: assert property (reg_rd_stb && reg_addr[7:1] != 7'h01
        |=> reg_rdata_q == 8'h00) else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!reg_rd_stb |=> $stable(reg_rdata_q))
        else $error("read data moved");
    chk_alert_fall: assert property ($fell(port1_alert_req_q) |-> !$past(any_cond))
        else $error("alert dropped with fault");
    chk_err_exit: assert property ($fell(port1_error_q) |-> !$past(any_cond))
        else $error("error left with fault");
    chk_flag_keep: assert property (fs_rd && thermal_cond && $past(thermal_cond)
        && $past(arst_n) |=> reg_rdata_q[3]) else $error("thermal flag lost");

    // main scenarios
    cover property (fs_rd && port1_error_q);
    cover property (port1_error_q ##1 !port1_error_q);
    cover property (port1_error_q && $fell(port1_alert_req_q));
endmodule // pfsr_status_regs_monitor

bind pfsr_status_regs pfsr_status_regs_monitor u_monitor (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_rd_stb(reg_rd_stb),
    .reg_rdata_q(reg_rdata_q), .discharge_fail_cond(discharge_fail_cond),
    .low_bus_cond(low_bus_cond), .thermal_cond(thermal_cond),
    .supply_ov_cond(supply_ov_cond), .back_bias_cond(back_bias_cond),
    .over_limit_cond(over_limit_cond), .over_region2_cond(over_region2_cond),
    .port1_alert_req_q(port1_alert_req_q), .port1_error_q(port1_error_q));

`default_nettype wire

// [tb/pfsr_host_model.sv]
// pfsr_host_model.sv - host issuing single-byte register reads and writes
`default_nettype none

module pfsr_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output logic [7:0]      addr = 8'h00,
    output logic            rd_stb = 1'b0,
    output logic            wr_stb = 1'b0,
    output logic [7:0]      wdata = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;

    // one access: request held over the taking edge, then lines released
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] v,
                        output logic [7:0] d);
        @(posedge clk);
        addr   <= a;
        wdata  <= v;
        rd_stb <= !wr;
        wr_stb <= wr;
        @(posedge clk);
        rd_stb <= 1'b0;
        wr_stb <= 1'b0;
        addr   <= ~a; // released lines show a changed value
        wdata  <= ~v;
        #1;
        d = rdata;
    endtask
endmodule // pfsr_host_model

`default_nettype wire

// [tb/pfsr_status_regs_tb.sv]
// pfsr_status_regs_tb.sv - self-checking bench for the port fault status registers
`default_nettype none

module pfsr_status_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] PS = pfsr_pkg::PFSR_ADDR_PIN_STATUS;
    localparam logic [7:0] FS = pfsr_pkg::PFSR_ADDR_FAULT_STATUS;

    logic       clk = 1'b0, arst_n = 1'b0, en = 1'b0, auto_en = 1'b0, lim_only = 1'b0;
    logic       rd_stb, wr_stb, alert_q, err_q;
    logic [7:0] addr, wdata, rdata, rd_val, m;
    logic [6:0] cond = 7'h00;
    logic [5:0] pins = 6'h00;
    int         n_errors = 0, num_checks = 0, cycles = 0;

    always #5 clk = ~clk;

    // host model and block under test
    pfsr_host_model u_host (.clk(clk), .rdata(rdata), .addr(addr), .rd_stb(rd_stb),
                            .wr_stb(wr_stb), .wdata(wdata));
    pfsr_status_regs u_dut (
        .clk(clk), .arst_n(arst_n), .reg_addr(addr), .reg_rd_stb(rd_stb),
        .reg_wr_stb(wr_stb), .reg_wdata(wdata), .reg_rdata_q(rdata),
        .port1_alert_level(pins[0]), .port2_alert_level(pins[1]),
        .port1_const_current(pins[2]), .port2_const_current(pins[3]),
        .port1_attach_level(pins[4]), .port2_attach_level(pins[5]),
        .over_limit_cond(cond[0] | lim_only), .over_region2_cond(cond[0]),
        .back_bias_cond(cond[1]), .supply_ov_cond(cond[2]), .thermal_cond(cond[3]),
        .low_bus_cond(cond[4]), .discharge_fail_cond(cond[6]),
        .port_power_enable_ctrl(en), .auto_recovery_en(auto_en),
        .port1_alert_req_q(alert_q), .port1_error_q(err_q));

    // expected pin view: alerts, constant current, attach read inverted
    function automatic logic [7:0] exp_pin(input logic [5:0] p);
        return {p[1], p[0], p[3], p[2], 2'h0, ~p[5], ~p[4]};
    endfunction

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rd(input logic [7:0] a);
        u_host.xfer(1'b0, a, 8'h00, rd_val);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        u_host.xfer(1'b1, a, v, rd_val);
    endtask

    task automatic complete_run;
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // cycle ceiling against a hung run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            complete_run();
        end
    end

    initial begin
        void'($urandom(18));
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd(FS);
        check("reset_ind", rd_val, 8'h20);
        rd(FS);
        check("reset_ind_rd", rd_val, 8'h00);
        // random pin levels, ignored writes, unmapped reads
        repeat (8) begin
            @(posedge clk);
            pins <= 6'($urandom);
            wr(PS, 8'($urandom));
            rd(PS);
            check("pin_status", rd_val, exp_pin(pins));
            rd(8'($urandom_range(255, 4)));
            check("unmapped", rd_val, 8'h00);
        end
        // every fault cause: entry, refused clear, read clear or auto exit
        for (int k = 0; k < 7; k++) begin
            if (k == 5) continue;
            m = 8'h01 << k;
            @(posedge clk);
            cond <= m[6:0];
            repeat (2) @(posedge clk);
            wr(FS, 8'h00);
            check("fault_entry", {alert_q, err_q}, 2'h3);
            repeat (2) begin
                rd(FS);
                check("flag_set", rd_val, 8'h80 | m);
            end
            @(posedge clk);
            cond    <= 7'h00;
            auto_en <= k[0];
            rd(FS);
            check("pre_clear", rd_val, k[0] ? 8'h00 : 8'h80 | m);
            @(posedge clk);
            auto_en <= 1'b0;
            rd(FS);
            check("after_read", rd_val, k[0] ? 8'h00 : 8'h80);
            check("alert_free", {alert_q, err_q}, k[0] ? 2'h0 : 2'h1);
            wr(FS, 8'h00);
            check("err_clear", err_q, 1'b0);
        end
        @(posedge clk);
        lim_only <= 1'b1;
        wr(FS, 8'h80);
        check("limit_only", {alert_q, err_q}, 2'h0);
        @(posedge clk);
        lim_only <= 1'b0;
        // second reset, then an enable toggle drops the reset indicator
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        en <= 1'b1;
        rd(FS);
        check("toggle_clr", rd_val, 8'h00);
        complete_run();
    end
endmodule // pfsr_status_regs_tb

`default_nettype wire
